// ===== design/prioritized_interrupt_vectoring.v
// interrupt controller: request flags, enables, priority and vectored call
//
// Contract
// - time base flag, enable, global enable, stack not full: call 10H.
// - vectoring to time base clears its flag and global enable.
// - each clock tick pulse sets the tick flag, bit 5 of second register.
// - tick flag, enable, global enable, stack not full: call 14H.
// - vectoring to tick clears its flag and global enable.
// - other acknowledgments held until enabling return or enables set again.
// - enabling return sets global enable; plain return leaves it alone.
// - requests between two phase-two pulses are serviced at the later pulse.
// - fixed priority 04H, 08H, 0CH, 10H, 14H for simultaneous requests.
// - global enable cleared masks every source.
// - disabled request not serviced, but its flag still recorded.
// - flags stay set until serviced or cleared by software.
// - first register: enables bits 0-3, flags bits 4-6, bit 7 zero.
// - second register: enables bits 0-1, flags bits 4-5, rest zero.
// - external pins set flags on chosen edge; vectoring clears flag, global.
// - no acknowledgment while the return stack is full.
`include "irq_ctrl_defs.vh"

module prioritized_interrupt_vectoring #(
  parameter AW = 8,
  parameter VW = 11
) (
  // clock, reset, enable
  input  wire          clock,
  input  wire          srst,
  input  wire          clk_en,
  // register port
  input  wire [AW-1:0] addr,
  input  wire [7:0]    wdata,
  input  wire          wr,
  input  wire          rd,
  output reg  [7:0]    rdata,
  // processor core
  input  wire          phase_two_pulse,
  input  wire          stack_full,
  input  wire          irq_exit_restore,
  input  wire          subroutine_exit,
  output reg           call_req,
  output reg  [VW-1:0] call_vector,
  // request sources
  input  wire          ext_pin_a,
  input  wire          ext_pin_b,
  input  wire          counter_overflow,
  input  wire          timebase_tick,
  input  wire          clock_tick,
  // host interrupt
  output reg           irq
);

  // -----------------------------
  // state
  // -----------------------------
  reg                global_irq_enable_reg;
  reg  [`NUM_SRC-1:0] src_en_reg;
  reg  [`NUM_SRC-1:0] src_flag_reg;
  reg  [3:0]         edge_sel_reg;
  reg  [7:0]         status_reg;
  reg  [7:0]         mask_reg;
  reg  [7:0]         rdata_next;
  reg  [`NUM_SRC-1:0] flag_next;
  reg  [`NUM_SRC-1:0] sw_clr;
  reg  [VW-1:0]      vec_next;
  reg  [7:0]         status_next;

  wire               ext_a_edge;
  wire               ext_b_edge;
  wire [`NUM_SRC-1:0] raw_evt;
  wire [`NUM_SRC-1:0] eligible;
  wire [`NUM_SRC-1:0] grant;
  wire               ack;
  wire               wr_first;
  wire               wr_second;

  // -----------------------------
  // external pin edge detectors
  // -----------------------------
  pin_edge_detect u_edge_a (
    .clock      (clock),
    .srst       (srst),
    .clk_en     (clk_en),
    .pin        (ext_pin_a),
    .edge_sel   (edge_sel_reg[1:0]),
    .edge_pulse (ext_a_edge)
  );

  pin_edge_detect u_edge_b (
    .clock      (clock),
    .srst       (srst),
    .clk_en     (clk_en),
    .pin        (ext_pin_b),
    .edge_sel   (edge_sel_reg[3:2]),
    .edge_pulse (ext_b_edge)
  );

  // internal sources are same-clock pulses, pins come through synchronisers
  assign raw_evt = {clock_tick, timebase_tick, counter_overflow, ext_b_edge, ext_a_edge};

  // -----------------------------
  // arbitration
  // -----------------------------
  // only enabled pending requests compete
  assign eligible = src_flag_reg & src_en_reg;

  irq_arbiter #(
    .N (`NUM_SRC)
  ) u_arb (
    .eligible (eligible),
    .grant    (grant)
  );

  // acknowledge only at a phase-two pulse, globally enabled, stack has room
  assign ack = phase_two_pulse & global_irq_enable_reg & ~stack_full & (|eligible);

  assign wr_first  = wr & (addr == `ADDR_CTRL_FIRST);
  assign wr_second = wr & (addr == `ADDR_CTRL_SECOND);

  // -----------------------------
  // vector lookup from the one-hot grant
  // -----------------------------
  always @* begin
    vec_next = `VEC_EXT_A;
    case (1'b1)
      grant[`SRC_EXT_A]:    vec_next = `VEC_EXT_A;
      grant[`SRC_EXT_B]:    vec_next = `VEC_EXT_B;
      grant[`SRC_COUNTER]:  vec_next = `VEC_COUNTER;
      grant[`SRC_TIMEBASE]: vec_next = `VEC_TIMEBASE;
      grant[`SRC_TICK]:     vec_next = `VEC_TICK;
      default:              vec_next = `VEC_EXT_A;
    endcase
  end

  // -----------------------------
  // software flag clears: a write of zero to a flag bit clears it
  // -----------------------------
  always @* begin
    sw_clr = {`NUM_SRC{1'b0}};
    if (wr_first) begin
      sw_clr[`SRC_EXT_A]   = ~wdata[`F1_EXT_A_FLAG];
      sw_clr[`SRC_EXT_B]   = ~wdata[`F1_EXT_B_FLAG];
      sw_clr[`SRC_COUNTER] = ~wdata[`F1_COUNTER_FLAG];
    end
    if (wr_second) begin
      sw_clr[`SRC_TIMEBASE] = ~wdata[`F2_TIMEBASE_FLAG];
      sw_clr[`SRC_TICK]     = ~wdata[`F2_TICK_FLAG];
    end
  end

  // -----------------------------
  // flag update: service clear, software clear, then a new event wins
  // -----------------------------
  always @* begin
    flag_next = src_flag_reg;
    if (ack) begin
      flag_next = flag_next & ~grant;
    end
    flag_next = flag_next & ~sw_clr;
    // software may also set a flag by writing one
    if (wr_first) begin
      flag_next[`SRC_EXT_A]   = flag_next[`SRC_EXT_A] | wdata[`F1_EXT_A_FLAG];
      flag_next[`SRC_EXT_B]   = flag_next[`SRC_EXT_B] | wdata[`F1_EXT_B_FLAG];
      flag_next[`SRC_COUNTER] = flag_next[`SRC_COUNTER] | wdata[`F1_COUNTER_FLAG];
    end
    if (wr_second) begin
      flag_next[`SRC_TIMEBASE] = flag_next[`SRC_TIMEBASE] | wdata[`F2_TIMEBASE_FLAG];
      flag_next[`SRC_TICK]     = flag_next[`SRC_TICK] | wdata[`F2_TICK_FLAG];
    end
    // an event in the clearing cycle is not lost
    flag_next = flag_next | raw_evt;
  end

  // -----------------------------
  // enables and global enable
  // -----------------------------
  always @(posedge clock) begin
    if (srst) begin
      global_irq_enable_reg <= 1'b0;
      src_en_reg            <= {`NUM_SRC{1'b0}};
      edge_sel_reg          <= `RST_EDGE_SEL;
      src_flag_reg          <= {`NUM_SRC{1'b0}};
    end else if (clk_en) begin
      src_flag_reg <= flag_next;
      if (wr_first) begin
        src_en_reg[`SRC_EXT_A]   <= wdata[`F1_EXT_A_EN];
        src_en_reg[`SRC_EXT_B]   <= wdata[`F1_EXT_B_EN];
        src_en_reg[`SRC_COUNTER] <= wdata[`F1_COUNTER_EN];
      end
      if (wr_second) begin
        src_en_reg[`SRC_TIMEBASE] <= wdata[`F2_TIMEBASE_EN];
        src_en_reg[`SRC_TICK]     <= wdata[`F2_TICK_EN];
      end
      if (wr & (addr == `ADDR_EDGE_SEL)) begin
        edge_sel_reg <= wdata[3:0];
      end
      // acknowledge blocks nesting; enabling return reopens it
      if (ack) begin
        global_irq_enable_reg <= 1'b0;
      end else if (irq_exit_restore) begin
        global_irq_enable_reg <= 1'b1;
      end else if (wr_first) begin
        global_irq_enable_reg <= wdata[`F1_GLOBAL_EN];
      end
      // plain return deliberately has no branch here, so a same-cycle
      // software write or enabling return is never overridden by it
    end
  end

  // -----------------------------
  // call request to the core, one cycle per acknowledgment
  // -----------------------------
  always @(posedge clock) begin
    if (srst) begin
      call_req    <= 1'b0;
      call_vector <= {VW{1'b0}};
    end else if (clk_en) begin
      call_req <= ack;
      if (ack) begin
        call_vector <= vec_next;
      end
    end
  end

  // -----------------------------
  // host status, sticky per source, cleared by reading it
  // -----------------------------
  always @* begin
    status_next = status_reg;
    if (rd & (addr == `ADDR_IRQ_STATUS)) begin
      status_next = `RST_BYTE;
    end
    // set wins over the read clear
    status_next[`NUM_SRC-1:0] = status_next[`NUM_SRC-1:0] | raw_evt;
  end

  always @(posedge clock) begin
    if (srst) begin
      status_reg <= `RST_BYTE;
      mask_reg   <= `RST_BYTE;
      irq        <= 1'b0;
    end else if (clk_en) begin
      status_reg <= status_next;
      if (wr & (addr == `ADDR_IRQ_MASK)) begin
        mask_reg <= wdata;
      end
      irq <= |(status_next & mask_reg);
    end
  end

  // -----------------------------
  // read mux; unmapped addresses read zero
  // -----------------------------
  always @* begin
    rdata_next = `RST_BYTE;
    case (addr)
      `ADDR_CTRL_FIRST: begin
        rdata_next[`F1_GLOBAL_EN]    = global_irq_enable_reg;
        rdata_next[`F1_EXT_A_EN]     = src_en_reg[`SRC_EXT_A];
        rdata_next[`F1_EXT_B_EN]     = src_en_reg[`SRC_EXT_B];
        rdata_next[`F1_COUNTER_EN]   = src_en_reg[`SRC_COUNTER];
        rdata_next[`F1_EXT_A_FLAG]   = src_flag_reg[`SRC_EXT_A];
        rdata_next[`F1_EXT_B_FLAG]   = src_flag_reg[`SRC_EXT_B];
        rdata_next[`F1_COUNTER_FLAG] = src_flag_reg[`SRC_COUNTER];
      end
      `ADDR_CTRL_SECOND: begin
        rdata_next[`F2_TIMEBASE_EN]   = src_en_reg[`SRC_TIMEBASE];
        rdata_next[`F2_TICK_EN]       = src_en_reg[`SRC_TICK];
        rdata_next[`F2_TIMEBASE_FLAG] = src_flag_reg[`SRC_TIMEBASE];
        rdata_next[`F2_TICK_FLAG]     = src_flag_reg[`SRC_TICK];
      end
      `ADDR_IRQ_STATUS: rdata_next = status_reg;
      `ADDR_IRQ_MASK:   rdata_next = mask_reg;
      `ADDR_EDGE_SEL:   rdata_next = {4'h0, edge_sel_reg};
      default:          rdata_next = `RST_BYTE;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (srst) begin
      rdata <= `RST_BYTE;
    end else if (clk_en) begin
      rdata <= rd ? rdata_next : `RST_BYTE;
    end
  end

endmodule

// ===== design/irq_ctrl_defs.vh
// register offsets, field positions, vectors and reset values of the interrupt controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

// register addresses (data memory space)
`define ADDR_CTRL_FIRST   8'h0b
`define ADDR_CTRL_SECOND  8'h1e
`define ADDR_IRQ_STATUS   8'h20
`define ADDR_IRQ_MASK     8'h21
`define ADDR_EDGE_SEL     8'h22

// first control register fields
`define F1_GLOBAL_EN      0
`define F1_EXT_A_EN       1
`define F1_EXT_B_EN       2
`define F1_COUNTER_EN     3
`define F1_EXT_A_FLAG     4
`define F1_EXT_B_FLAG     5
`define F1_COUNTER_FLAG   6

// second control register fields
`define F2_TIMEBASE_EN    0
`define F2_TICK_EN        1
`define F2_TIMEBASE_FLAG  4
`define F2_TICK_FLAG      5

// source indices, also priority order (0 highest)
`define SRC_EXT_A         0
`define SRC_EXT_B         1
`define SRC_COUNTER       2
`define SRC_TIMEBASE      3
`define SRC_TICK          4
`define NUM_SRC           5

// call vectors
`define VEC_EXT_A         11'h004
`define VEC_EXT_B         11'h008
`define VEC_COUNTER       11'h00c
`define VEC_TIMEBASE      11'h010
`define VEC_TICK          11'h014

// edge select codes per external pin
`define EDGE_FALL         2'h0
`define EDGE_RISE         2'h1
`define EDGE_BOTH         2'h2

// reset values
`define RST_BYTE          8'h00
`define RST_EDGE_SEL      4'h0

`endif

// ===== design/pin_edge_detect.v
// external interrupt pin synchroniser with selectable edge detection
`include "irq_ctrl_defs.vh"

module pin_edge_detect (
  // clock and reset
  input  wire       clock,
  input  wire       srst,
  input  wire       clk_en,
  // pin and edge selection
  input  wire       pin,
  input  wire [1:0] edge_sel,
  // one-cycle edge pulse
  output reg        edge_pulse
);

  reg sync1_reg;
  reg sync2_reg;
  reg last_reg;

  // -----------------------------
  // two-stage synchroniser, then edge compare on the second stage only
  // -----------------------------
  always @(posedge clock) begin
    if (srst) begin
      sync1_reg  <= 1'b1;
      sync2_reg  <= 1'b1;
      last_reg   <= 1'b1;
      edge_pulse <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      case (edge_sel)
        `EDGE_FALL: edge_pulse <= last_reg & ~sync2_reg;
        `EDGE_RISE: edge_pulse <= ~last_reg & sync2_reg;
        `EDGE_BOTH: edge_pulse <= last_reg ^ sync2_reg;
        default:    edge_pulse <= last_reg & ~sync2_reg;
      endcase
    end
  end

endmodule

// ===== design/irq_arbiter.v
// fixed priority pick among enabled pending requests
`include "irq_ctrl_defs.vh"

module irq_arbiter #(
  parameter N = 5
) (
  // requests already gated by their own enable
  input  wire [N-1:0] eligible,
  // one-hot grant, lowest index wins
  output wire [N-1:0] grant
);

  wire [N:0] taken;

  assign taken[0] = 1'b0;

  // -----------------------------
  // ripple priority chain; a disabled request never blocks a lower one
  // -----------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pri
      assign grant[i]   = eligible[i] & ~taken[i];
      assign taken[i+1] = taken[i] | eligible[i];
    end
  endgenerate

endmodule

// ===== bench/core_model.sv
// processor core stand-in: phase-two pulses, stack level and return pulses
module core_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // requests from the bench
  input  wire logic full_set,
  input  wire logic ret_irq,
  input  wire logic ret_sub,
  // to the controller
  output logic      phase_two_pulse,
  output logic      stack_full,
  output logic      irq_exit_restore,
  output logic      subroutine_exit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg;
  // defined levels before the first edge
  initial begin
    div_reg = 2'h0;
    phase_two_pulse = 1'b0;
    stack_full = 1'b0;
    irq_exit_restore = 1'b0;
    subroutine_exit = 1'b0;
  end
  // one sample pulse every fourth cycle, as in a four-phase instruction cycle
  always @(posedge clock) begin
    div_reg <= srst ? 2'h0 : div_reg + 2'h1;
    phase_two_pulse <= !srst && div_reg == 2'h1;
    stack_full <= full_set;
    irq_exit_restore <= ret_irq;
    subroutine_exit <= ret_sub;
  end
endmodule

// ===== bench/irq_ctrl_props.sv
// checker: port-level properties of the interrupt controller
module irq_ctrl_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register port and core link
  input wire logic [7:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        phase_two_pulse,
  input wire logic        stack_full,
  input wire logic        irq_exit_restore,
  input wire logic        call_req,
  input wire logic [10:0] call_vector,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // nothing can reopen the global enable in these cycles
  sequence quiet_s;
    !irq_exit_restore && !wr;
  endsequence
  call_pulse_a: assert property (call_req |=> !call_req)
    else $error("call request longer than one cycle");
  call_phase_a: assert property ($rose(call_req) |-> $past(phase_two_pulse) && !$past(stack_full))
    else $error("call outside a sample pulse or with stack full");
  vector_set_a: assert property (call_req |-> call_vector inside
    {11'h004, 11'h008, 11'h00c, 11'h010, 11'h014})
    else $error("call vector not a documented vector");
  vector_hold_a: assert property (!call_req && !$past(srst) |-> $stable(call_vector))
    else $error("call vector moved without a call");
  read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  first_pad_a: assert property ($past(rd) && $past(addr) == 8'h0b |-> !rdata[7])
    else $error("first control register bit 7 not zero");
  second_pad_a: assert property ($past(rd) && $past(addr) == 8'h1e |-> (rdata & 8'hcc) == 8'h00)
    else $error("second control register unused bits not zero");
  hold_off_a: assert property (call_req ##1 quiet_s [*6] |-> !call_req)
    else $error("second call without re-enable");
  irq_drop_a: assert property ($fell(irq) |-> $past(rd) || $past(wr, 2) || $past(srst))
    else $error("interrupt line dropped without a status read or mask write");
endmodule

bind prioritized_interrupt_vectoring irq_ctrl_props props (
  .clock(clock), .srst(srst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
  .phase_two_pulse(phase_two_pulse), .stack_full(stack_full),
  .irq_exit_restore(irq_exit_restore), .call_req(call_req),
  .call_vector(call_vector), .irq(irq));

// ===== bench/tb_top.sv
// self-checking bench for the interrupt controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [10:0] call_vector;
  logic        call_req, irq, p2, full, rti, rts;
  logic        full_set = 1'b0, ret_irq = 1'b0, ret_sub = 1'b0, pin_a = 1'b1, pin_b = 1'b1;
  logic [2:0]  evt = 3'h0;
  int          failures = 0, n_checks = 0, n_calls = 0, c;
  // ----------------------------------------
  // instances and clock
  // ----------------------------------------
  core_model core (.clock(clock), .srst(srst), .full_set(full_set), .ret_irq(ret_irq),
    .ret_sub(ret_sub), .phase_two_pulse(p2), .stack_full(full), .irq_exit_restore(rti),
    .subroutine_exit(rts));
  prioritized_interrupt_vectoring dut (.clock(clock), .srst(srst), .clk_en(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_two_pulse(p2),
    .stack_full(full), .irq_exit_restore(rti), .subroutine_exit(rts), .call_req(call_req),
    .call_vector(call_vector), .ext_pin_a(pin_a), .ext_pin_b(pin_b),
    .counter_overflow(evt[0]), .timebase_tick(evt[1]), .clock_tick(evt[2]), .irq(irq));
  always #25 clock = ~clock;
  // calls are counted so that an unwanted call is seen, not only a wrong vector
  always @(posedge clock) if (call_req === 1'b1) n_calls <= n_calls + 1;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= 3'h0;
  endtask
  task automatic wait_call(input logic [10:0] exp);
    for (int i = 0; i < 40; i++) begin
      @(negedge clock);
      if (call_req === 1'b1) break;
    end
    chk({call_req, call_vector}, {1'b1, exp});
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clock);
    #1 chk(irq, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rreg(8'h0b, 8'h00);
    rreg(8'h1e, 8'h00);
    rreg(8'h21, 8'h00);
    rreg(8'h55, 8'h00);
  endtask
  task automatic t_timebase;
    wreg(8'h1e, 8'h01);
    wreg(8'h0b, 8'h01);
    pulse(3'h2);
    wait_call(11'h010);
    rreg(8'h1e, 8'h01);
    @(posedge clock) ret_sub <= 1'b1;
    @(posedge clock) ret_sub <= 1'b0;
    rreg(8'h0b, 8'h00);
  endtask
  // counter flag left pending but disabled must not block the tick
  task automatic t_tick;
    wreg(8'h1e, 8'h02);
    c = n_calls;
    pulse(3'h5);
    repeat (8) @(posedge clock);
    chk(n_calls, c);
    rreg(8'h1e, 8'h22);
    wreg(8'h0b, 8'h41);
    wait_call(11'h014);
    rreg(8'h1e, 8'h02);
    rreg(8'h0b, 8'h40);
  endtask
  task automatic t_prio;
    wreg(8'h0b, 8'h4e);
    wreg(8'h1e, 8'h03);
    pulse(3'h7);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (8) @(posedge clock);
    rreg(8'h0b, 8'h7e);
    wreg(8'h0b, 8'h7f);
    wait_call(11'h004);
    rreg(8'h0b, 8'h6e);
    for (int i = 1; i < 5; i++) begin
      @(posedge clock) ret_irq <= 1'b1;
      @(posedge clock) ret_irq <= 1'b0;
      wait_call(11'(4 * i + 4));
    end
    wreg(8'h22, 8'h06);
    pin_a <= 1'b1;
    pin_b <= 1'b1;
    repeat (8) @(posedge clock);
    rreg(8'h0b, 8'h3e);
    wreg(8'h0b, 8'h0e);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
    repeat (8) @(posedge clock);
    rreg(8'h0b, 8'h1e);
  endtask
  task automatic t_full;
    wreg(8'h0b, 8'h00);
    wreg(8'h1e, 8'h02);
    full_set <= 1'b1;
    wreg(8'h0b, 8'h01);
    pulse(3'h4);
    c = n_calls;
    repeat (16) @(posedge clock);
    chk(n_calls, c);
    full_set <= 1'b0;
    wait_call(11'h014);
  endtask
  task automatic t_irq;
    rreg(8'h20, 8'h1f);
    wreg(8'h21, 8'h10);
    pulse(3'h4);
    irq_chk(1'b1);
    wreg(8'h21, 8'h00);
    irq_chk(1'b0);
    wreg(8'h21, 8'h10);
    irq_chk(1'b1);
    rreg(8'h20, 8'h10);
    irq_chk(1'b0);
    // a write while the clock enable is low must leave the mask untouched
    ce <= 1'b0;
    wreg(8'h21, 8'hff);
    ce <= 1'b1;
    rreg(8'h21, 8'h10);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    t_reset;
    t_timebase;
    t_tick;
    t_prio;
    t_full;
    t_irq;
    stop_test;
  end
  // the scenarios need under a thousand cycles; cut a hang well beyond that
  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
